// ### rtl/dtmfsr_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtmfsr_consts.svh"
module dtmfsr_host #(
  parameter bit DELAYED = 1'b0,
  parameter int GUARD_CYC = `DTMFSR_GUARD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // User side
  input wire logic sleep_cmd,
  output logic [3:0] digit,
  output logic digit_valid,
  output logic cadence,
  output logic [31:0] cadence_len,
  output logic cadence_edge,
  // Link to the device
  dtmfsr_if.host link
);
  import dtmfsr_pkg::*;

  logic [2:0] stf_q;
  logic [2:0] sdi_q;
  logic steer_lvl_q;
  logic sd_lvl_q;
  logic [31:0] gcnt_q;
  logic armed_q;
  logic done_q;
  dtmfsr_hstate_t st_q;
  logic [7:0] tcnt_q;
  logic [2:0] pcnt_q;
  logic [3:0] acc_q;
  logic shift_q;
  logic sleep_q;
  logic [31:0] clen_q;
  logic [3:0] quiet_q;

  // Input synchronisers, level taken when the two oldest stages agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stf_q <= 3'h0;
      sdi_q <= 3'h0;
      steer_lvl_q <= 1'b0;
      sd_lvl_q <= 1'b0;
    end
    else
    begin
      stf_q <= {stf_q[1:0], DELAYED ? link.valid_digit_flag : link.early_tone_flag};
      sdi_q <= {sdi_q[1:0], link.serial_digit_out};
      if (stf_q[1] == stf_q[2])
        steer_lvl_q <= stf_q[2];
      if (sdi_q[1] == sdi_q[2])
        sd_lvl_q <= sdi_q[2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !steer_lvl_q)
    begin
      gcnt_q <= 32'h0;
      armed_q <= 1'b0;
    end
    else if (DELAYED || gcnt_q >= GUARD_CYC - 1)
      armed_q <= 1'b1;
    else
      gcnt_q <= gcnt_q + 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sleep_q <= 1'b0;
    else
      sleep_q <= sleep_cmd && st_q == DTMFSR_H_IDLE;
  end
  assign link.sleep_request = sleep_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= DTMFSR_H_IDLE;
      tcnt_q <= 8'h0;
      pcnt_q <= 3'h0;
      acc_q <= 4'h0;
      shift_q <= 1'b0;
      done_q <= 1'b0;
      digit <= 4'h0;
      digit_valid <= 1'b0;
    end
    else
    begin
      digit_valid <= 1'b0;
      if (!steer_lvl_q)
        done_q <= 1'b0;
      unique case (st_q)
        DTMFSR_H_IDLE:
          if (armed_q && !done_q && !sleep_q && !sleep_cmd)
          begin
            st_q <= DTMFSR_H_HIGH;
            shift_q <= 1'b1;
            tcnt_q <= 8'h0;
            pcnt_q <= 3'h0;
          end
        DTMFSR_H_HIGH:
          if (tcnt_q == `DTMFSR_HALF_CYC - 8'h1)
          begin
            st_q <= DTMFSR_H_LOW;
            shift_q <= 1'b0;
            tcnt_q <= 8'h0;
          end
          else
            tcnt_q <= tcnt_q + 8'h1;
        DTMFSR_H_LOW:
          if (tcnt_q == `DTMFSR_HALF_CYC - 8'h1)
          begin
            acc_q <= {acc_q[2:0], sd_lvl_q};
            tcnt_q <= 8'h0;
            if (pcnt_q == `DTMFSR_SHIFT_PULSES - 3'h1)
            begin
              st_q <= DTMFSR_H_IDLE;
              digit <= {acc_q[2:0], sd_lvl_q};
              digit_valid <= 1'b1;
              done_q <= 1'b1;
            end
            else
            begin
              st_q <= DTMFSR_H_HIGH;
              shift_q <= 1'b1;
              pcnt_q <= pcnt_q + 3'h1;
            end
          end
          else
            tcnt_q <= tcnt_q + 8'h1;
      endcase
    end
  end
  assign link.shift_pulse_in = shift_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cadence <= 1'b0;
      clen_q <= 32'h0;
      cadence_len <= 32'h0;
      cadence_edge <= 1'b0;
      quiet_q <= 4'h0;
    end
    else
    begin
      cadence_edge <= 1'b0;
      quiet_q <= {quiet_q[2:0], 1'b0};
      // Serial pin lags steering, so stay deaf a few cycles more
      if (steer_lvl_q || st_q != DTMFSR_H_IDLE)
      begin
        clen_q <= 32'h0;
        quiet_q <= 4'hF;
      end
      else if (quiet_q != 4'h0)
        clen_q <= 32'h0;
      else if (sd_lvl_q != cadence)
      begin
        cadence <= sd_lvl_q;
        cadence_len <= clen_q;
        cadence_edge <= 1'b1;
        clen_q <= 32'h1; // Edge cycle opens the new level
      end
      else
        clen_q <= clen_q + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ### inc/dtmfsr_consts.svh
`ifndef DTMFSR_CONSTS_SVH
`define DTMFSR_CONSTS_SVH

// Digit code width and bits per readout
`define DTMFSR_CODE_W 4
`define DTMFSR_SHIFT_PULSES 3'h4
// Reference clock rate in Hz
`define DTMFSR_REF_HZ 4194304
// System clock period in ns
`define DTMFSR_CLK_NS 10
// Guard time in microseconds (device guard when delayed, host guard when early)
`define DTMFSR_GUARD_US 40
`define DTMFSR_GUARD_CYC ((`DTMFSR_GUARD_US * 1000 + `DTMFSR_CLK_NS - 1) / `DTMFSR_CLK_NS)
// Host shift pulse half period, cycles
`define DTMFSR_HALF_CYC 8'h08
// Customary keypad codes, key index 0..15 = 1..9,0,*,#,A,B,C,D
`define DTMFSR_CODE_STAR 4'hB
`define DTMFSR_CODE_HASH 4'hC
`define DTMFSR_CODE_D 4'h0

`endif

// ### inc/dtmfsr_pkg.sv
package dtmfsr_pkg;
  typedef logic [3:0] dtmfsr_code_t;
  typedef logic [3:0] dtmfsr_key_t;
  typedef enum logic [2:0]
  {
    DTMFSR_H_IDLE = 3'h1,
    DTMFSR_H_HIGH = 3'h2,
    DTMFSR_H_LOW = 3'h4
  } dtmfsr_hstate_t;
endpackage

// ### inc/dtmfsr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dtmfsr_if;
  logic early_tone_flag;
  logic valid_digit_flag;
  logic serial_digit_out;
  logic shift_pulse_in;
  logic sleep_request;
  modport device (
    output early_tone_flag,
    output valid_digit_flag,
    output serial_digit_out,
    input shift_pulse_in,
    input sleep_request
  );
  modport host (
    input early_tone_flag,
    input valid_digit_flag,
    input serial_digit_out,
    output shift_pulse_in,
    output sleep_request
  );
endinterface
`default_nettype wire

// ### rtl/dtmfsr_device.sv
// Behaviour
// - Sixteen tone pairs map to 4-bit codes.
// - Early flag follows tone presence directly.
// - Host applies own guard on early flag.
// - Delayed flag rises after internal guard.
// - Code shifted out bit per pulse.
// - Serial pin shows digit, else cadence.
// - Cadence output follows tone burst envelope.
// - Host measures cadence on/off durations.
// - Cadence toggling during digits is ignored.
// - Serial pin low while powered down.
// - Timing derived from reference clock.
// - Power-down drives all outputs low.
// - Four pulses; first edge latches code.
// - Shift input idles low, pulled down.
// - Sleep request high powers device down.
// - Steering output low in power-down.
`timescale 1ns/10ps
`default_nettype none
`include "dtmfsr_consts.svh"
module dtmfsr_device #(
  parameter bit DELAYED = 1'b0,
  parameter int GUARD_CYC = `DTMFSR_GUARD_CYC
) (
  // Clock and reset
  // clk stands in for the reference
  input wire logic clk,
  input wire logic rst_n,
  // Detector results from the analog front end
  input wire logic tone_present,
  input wire dtmfsr_pkg::dtmfsr_key_t tone_key,
  input wire logic tone_cadence,
  // Link to the controller
  dtmfsr_if.device link
);
  import dtmfsr_pkg::*;

  function automatic dtmfsr_code_t key_code(input dtmfsr_key_t k);
    dtmfsr_code_t c;
    c = 4'h0;
    // Key index order 1..9, 0, star, hash, A..D
    case (k)
      4'hA: c = `DTMFSR_CODE_STAR;
      4'hB: c = `DTMFSR_CODE_HASH;
      4'hF: c = `DTMFSR_CODE_D;
      default: c = k + 4'h1;
    endcase
    return c;
  endfunction

  // Two oldest synchroniser stages agree
  function automatic logic settled(input logic [2:0] s);
    return s[1] == s[2];
  endfunction

  // Input synchronisers and sleep level
  logic [2:0] shp_q;
  logic [2:0] slp_q;
  logic sleep_q;
  logic shift_prev_q;
  logic shift_rise;

  // Guard timer and steering
  logic [31:0] guard_q;
  logic valid_q;
  logic steer_q;

  // Readout shift state
  logic [3:0] shreg_q;
  logic [2:0] bits_q;
  dtmfsr_code_t code_w;

  // Serial pin register
  logic sd_q;

  // Code of the key now heard
  assign code_w = key_code(tone_key);

  // shift input synchroniser
  // Cleared to low, as the pin pull-down
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      shp_q <= 3'h0;
    else
      shp_q <= {shp_q[1:0], link.shift_pulse_in};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      slp_q <= 3'h0;
      sleep_q <= 1'b0;
    end
    else
    begin
      slp_q <= {slp_q[1:0], link.sleep_request};
      if (settled(slp_q))
        sleep_q <= slp_q[2];
    end
  end

  // Debounced shift level and rising edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      shift_prev_q <= 1'b0;
    else if (settled(shp_q))
      shift_prev_q <= shp_q[2];
  end

  // Rising edge once the stages agree
  assign shift_rise = settled(shp_q) && shp_q[2] && !shift_prev_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n || sleep_q || !tone_present)
    begin
      guard_q <= 32'h0;
      valid_q <= 1'b0;
    end
    else if (guard_q >= GUARD_CYC - 1)
      valid_q <= 1'b1;
    else
      guard_q <= guard_q + 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || sleep_q)
      steer_q <= 1'b0;
    else
      steer_q <= DELAYED ? valid_q : tone_present;
  end
  assign link.early_tone_flag = DELAYED ? 1'b0 : steer_q;
  assign link.valid_digit_flag = DELAYED ? steer_q : 1'b0;

  // latch on first edge, then shift
  // one bit per pulse, MSB first
  always_ff @(posedge clk)
  begin
    if (!rst_n || sleep_q)
    begin
      shreg_q <= 4'h0;
      bits_q <= 3'h0;
    end
    else if (shift_rise)
    begin
      if (bits_q == 3'h0 && steer_q)
      begin
        shreg_q <= {code_w[2:0], 1'b0};
        bits_q <= `DTMFSR_SHIFT_PULSES - 3'h1;
      end
      else if (bits_q != 3'h0)
      begin
        shreg_q <= {shreg_q[2:0], 1'b0};
        bits_q <= bits_q - 3'h1;
      end
    end
  end

  // Current digit bit output, held across pulse
  logic dbit_q;
  logic dact_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n || sleep_q)
    begin
      dbit_q <= 1'b0;
      dact_q <= 1'b0;
    end
    else if (shift_rise && bits_q == 3'h0 && steer_q)
    begin
      dbit_q <= code_w[3];
      dact_q <= 1'b1;
    end
    else if (shift_rise && bits_q != 3'h0)
      dbit_q <= shreg_q[3];
    // Rise with no bits left and no steering hands the pin back to cadence
    else if (shift_rise)
      dact_q <= 1'b0;
    // Steering gone with shift low ends the digit
    else if (bits_q == 3'h0 && !shift_prev_q && !steer_q)
      dact_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || sleep_q)
      sd_q <= 1'b0;
    else
      sd_q <= dact_q ? dbit_q : tone_cadence;
  end
  assign link.serial_digit_out = sd_q;
endmodule
`default_nettype wire

// ### tb/dtmfsr_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dtmfsr_link_sva #(
  parameter bit DELAYED = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link signals
  input wire logic early_tone_flag,
  input wire logic valid_digit_flag,
  input wire logic serial_digit_out,
  input wire logic shift_pulse_in,
  input wire logic sleep_request
);
  logic steer;
  logic prev_q;
  logic [2:0] cnt_q;
  // Either steering flag
  assign steer = early_tone_flag | valid_digit_flag;
  // Last shift level
  always_ff @(posedge clk)
  begin
    prev_q <= rst_n & shift_pulse_in;
  end
  // Shift rises within one steering span
  always_ff @(posedge clk)
  begin
    if (!rst_n || !steer)
    begin
      cnt_q <= 3'h0;
    end
    else if (shift_pulse_in && !prev_q && cnt_q != 3'h7)
    begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  default clocking dck @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sd_sleep_low_a: assert property (sleep_request [*6] |-> !serial_digit_out)
    else $error("serial out high asleep");
  steer_sleep_low_a: assert property (sleep_request [*6] |-> !steer)
    else $error("steering high asleep");
  sleep_shift_low_a: assert property (sleep_request |-> !shift_pulse_in)
    else $error("shift high with sleep");
  unused_flag_low_a: assert property (DELAYED ? !early_tone_flag : !valid_digit_flag)
    else $error("wrong steering flag");
  shift_needs_steer_a: assert property ($rose(shift_pulse_in) |-> steer)
    else $error("shift without steering");
  shift_high_len_a: assert property ($rose(shift_pulse_in) |->
    shift_pulse_in [*8] ##1 !shift_pulse_in)
    else $error("shift high phase length");
  shift_low_len_a: assert property ($fell(shift_pulse_in) |-> !shift_pulse_in [*8])
    else $error("shift low phase length");
  four_pulse_max_a: assert property (cnt_q <= 3'h4)
    else $error("more than four pulses");
  wake_steer_a: assert property ($rose(steer) |-> !sleep_request)
    else $error("steering rose asleep");
  // Main scenarios
  full_read_c: cover property (cnt_q == 3'h4);
  asleep_c: cover property (sleep_request [*6]);
  steer_c: cover property ($rose(steer));
endmodule
`default_nettype wire

// ### tb/test_dtmf_digit_serial_readout.sv
`timescale 1ns/10ps
`default_nettype none
module test_dtmf_digit_serial_readout;
  import dtmfsr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tone_present = 1'b0;
  dtmfsr_key_t tone_key = 4'h0;
  logic tone_cadence = 1'b0;
  logic sleep_cmd = 1'b0;
  logic [3:0] digit;
  logic digit_valid;
  logic cadence;
  logic cadence_edge;
  logic [31:0] cadence_len;
  logic [3:0] digit2;
  logic digit_valid2;
  int err_total = 0;
  int total_checks = 0;
  int seed = 2785;
  int edges = 0;
  int e0;
  int base;
  localparam int GUARD = 10;
  dtmfsr_code_t exp_q[$];
  dtmfsr_code_t exp2_q[$];
  dtmfsr_if link ();
  dtmfsr_if link2 ();
  dtmfsr_device #(.DELAYED(1'b0), .GUARD_CYC(GUARD)) i_dtmfsr_device (.clk(clk), .rst_n(rst_n),
    .tone_present(tone_present), .tone_key(tone_key), .tone_cadence(tone_cadence), .link(link));
  dtmfsr_host #(.DELAYED(1'b0), .GUARD_CYC(GUARD)) i_dtmfsr_host (.clk(clk), .rst_n(rst_n),
    .sleep_cmd(sleep_cmd), .digit(digit), .digit_valid(digit_valid), .cadence(cadence),
    .cadence_len(cadence_len), .cadence_edge(cadence_edge), .link(link));
  // Delayed-steering pair on the same tone inputs
  dtmfsr_device #(.DELAYED(1'b1), .GUARD_CYC(GUARD)) i_dtmfsr_device_dly (.clk(clk),
    .rst_n(rst_n), .tone_present(tone_present), .tone_key(tone_key),
    .tone_cadence(tone_cadence), .link(link2));
  dtmfsr_host #(.DELAYED(1'b1), .GUARD_CYC(GUARD)) i_dtmfsr_host_dly (.clk(clk), .rst_n(rst_n),
    .sleep_cmd(sleep_cmd), .digit(digit2), .digit_valid(digit_valid2), .cadence(),
    .cadence_len(), .cadence_edge(), .link(link2));
  dtmfsr_link_sva #(.DELAYED(1'b0)) i_dtmfsr_link_sva (.clk(clk), .rst_n(rst_n),
    .early_tone_flag(link.early_tone_flag), .valid_digit_flag(link.valid_digit_flag),
    .serial_digit_out(link.serial_digit_out), .shift_pulse_in(link.shift_pulse_in),
    .sleep_request(link.sleep_request));
  // Clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Delivered digits against oldest note, cadence edges counted
  always @(posedge clk)
  begin
    if (digit_valid === 1'b1)
    begin
      if (exp_q.size() > 0)
        check("digit", digit, exp_q.pop_front());
      else
        check("spare digit", 4'h1, 4'h0);
    end
    if (digit_valid2 === 1'b1)
    begin
      if (exp2_q.size() > 0)
        check("late digit", digit2, exp2_q.pop_front());
      else
        check("spare late digit", 4'h1, 4'h0);
    end
    if (cadence_edge === 1'b1)
      edges++;
  end
  // One tone pair to both variants, optional cadence chatter
  task automatic send_key(input dtmfsr_key_t key, input bit chatter);
    int n;
    n = 0;
    @(posedge clk);
    tone_key <= key;
    tone_present <= 1'b1;
    exp_q.push_back(key + 4'h1);
    exp2_q.push_back(key + 4'h1);
    e0 = edges;
    while (exp_q.size() + exp2_q.size() != 0 && n < 500)
    begin
      @(posedge clk);
      if (chatter && n > 20)
        tone_cadence <= ~tone_cadence;
      @(negedge clk);
      if (n == 0)
        check("early flag", {31'h0, link.early_tone_flag}, 32'h1);
      if (n == GUARD - 1)
        check("late flag early", {31'h0, link2.valid_digit_flag}, 32'h0);
      if (n == GUARD)
        check("late flag", {31'h0, link2.valid_digit_flag}, 32'h1);
      n++;
    end
    check("readout done", exp_q.size(), 32'h0);
    check("late readout done", exp2_q.size(), 32'h0);
    @(posedge clk);
    tone_present <= 1'b0;
    tone_cadence <= 1'b0;
    repeat (40) @(posedge clk);
    @(negedge clk);
    check("edges in digit", edges - e0, 32'h0);
  endtask
  // Watchdog
  initial
  begin
    #300000;
    err_total++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    base = $random(seed);
    for (int i = 0; i < 16; i++)
      send_key(4'(i + base), i[0]);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      tone_cadence <= ~i[0];
      e0 = edges;
      repeat (40) @(posedge clk);
      @(negedge clk);
      check("cadence", {3'h0, cadence}, {3'h0, ~i[0]});
      check("cadence edges", edges - e0, 32'h1);
      if (i > 0)
        check("cadence length", cadence_len, 32'h29);
    end
    @(posedge clk);
    tone_cadence <= 1'b1;
    sleep_cmd <= 1'b1;
    repeat (20) @(posedge clk);
    tone_present <= 1'b1;
    tone_key <= 4'($random(seed));
    repeat (40) @(posedge clk);
    @(negedge clk);
    check("sd asleep", {3'h0, link.serial_digit_out}, 4'h0);
    check("flag asleep", {3'h0, link.early_tone_flag}, 4'h0);
    check("late flag asleep", {3'h0, link2.valid_digit_flag}, 4'h0);
    check("late sd asleep", {3'h0, link2.serial_digit_out}, 4'h0);
    @(posedge clk);
    sleep_cmd <= 1'b0;
    tone_present <= 1'b0;
    tone_cadence <= 1'b0;
    repeat (40) @(posedge clk);
    send_key(4'($random(seed)), 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
